/* File: ram_blk_pkg.sv */
package ram_blk_pkg;

  localparam int ROWS = 512;
  localparam int ROW_W = 40;
  localparam int ADDR_W = 14;
  localparam int CAP_LARGE = 20480;
  localparam int CAP_LUT = 640;
  localparam int LUT_DEPTH_NATIVE = 32;
  localparam int LUT_DEPTH_EMUL = 64;
  localparam int LUT_EMUL_MAX_W = 10;
  localparam int PAR_GROUP = 5;
  localparam logic [39:0] DONT_CARE_VAL = 40'h00_0000_0000;

  typedef enum logic [5:0] {
    MODE_SP = 6'h01,
    MODE_SDP = 6'h02,
    MODE_TDP = 6'h04,
    MODE_SHIFT = 6'h08,
    MODE_ROM = 6'h10,
    MODE_FIFO = 6'h20
  } mem_mode_t;

  typedef enum logic [3:0] {
    CLK_SINGLE = 4'h1,
    CLK_RW = 4'h2,
    CLK_IO = 4'h4,
    CLK_INDEP = 4'h8
  } clk_mode_t;

  typedef enum logic [2:0] {
    RDW_NEW = 3'h1,
    RDW_OLD = 3'h2,
    RDW_DC = 3'h4
  } rdw_t;

  // width codes
  localparam logic [3:0] W1 = 4'h0;
  localparam logic [3:0] W2 = 4'h1;
  localparam logic [3:0] W4 = 4'h2;
  localparam logic [3:0] W5 = 4'h3;
  localparam logic [3:0] W8 = 4'h4;
  localparam logic [3:0] W9 = 4'h5;
  localparam logic [3:0] W10 = 4'h6;
  localparam logic [3:0] W16 = 4'h7;
  localparam logic [3:0] W18 = 4'h8;
  localparam logic [3:0] W20 = 4'h9;
  localparam logic [3:0] W32 = 4'ha;
  localparam logic [3:0] W40 = 4'hb;

  function automatic int width_of(logic [3:0] c);
    case (c)
      W1: return 1;
      W2: return 2;
      W4: return 4;
      W5: return 5;
      W8: return 8;
      W9: return 9;
      W10: return 10;
      W16: return 16;
      W18: return 18;
      W20: return 20;
      W32: return 32;
      default: return 40;
    endcase
  endfunction

  function automatic logic is_par(logic [3:0] c);
    return c == W5 || c == W10 || c == W20 || c == W40;
  endfunction

  // log2 of elements sharing one 40-bit row
  function automatic int row_shift(logic [3:0] c);
    case (c)
      W1: return 5;
      W2: return 4;
      W4, W5: return 3;
      W8, W10: return 2;
      W16, W20: return 1;
      default: return 0;
    endcase
  endfunction

endpackage

/* File: ram_blk.sv */
`timescale 1ns/1ps
module ram_blk #(
  parameter bit LUT_BLOCK = 1'b0,
  parameter bit HAS_RE = 1'b1,
  parameter bit OUT_REG = 1'b1,
  parameter bit ROM_ADDR_REG = 1'b1,
  parameter int TAP_LEN = 16,
  parameter int TAP_CNT = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ram_blk_pkg::mem_mode_t mem_mode,
  input wire ram_blk_pkg::clk_mode_t clk_mode,
  input wire ram_blk_pkg::rdw_t rdw_mode,
  input wire logic [3:0] wc_a,
  input wire logic [3:0] wc_b,
  input wire logic ce_a,
  input wire logic ce_b,
  input wire logic clr_a,
  input wire logic clr_b,
  input wire logic [13:0] addr_a,
  input wire logic [39:0] data_a,
  input wire logic we_a,
  input wire logic re_a,
  input wire logic [13:0] addr_b,
  input wire logic [39:0] data_b,
  input wire logic we_b,
  input wire logic re_b,
  output logic [39:0] q_a,
  output logic [39:0] q_b,
  output logic cfg_err,
  output logic emul,
  output logic collide
);
  import ram_blk_pkg::*;

  logic [39:0] mem [0:ROWS-1];
  logic [13:0] a_addr_r, a_addr_nxt, b_addr_r, b_addr_nxt;
  logic [39:0] a_wd_r, a_wd_nxt, b_wd_r, b_wd_nxt;
  logic a_we_r, a_we_nxt, a_re_r, a_re_nxt, a_go_r, a_go_nxt;
  logic b_we_r, b_we_nxt, b_re_r, b_re_nxt, b_go_r, b_go_nxt;
  logic [13:0] ptr_r, ptr_nxt;
  logic clr_a_m, clr_a_s, clr_b_m, clr_b_s;
  logic [39:0] lat_a_r, lat_a_nxt, lat_b_r, lat_b_nxt;
  logic [39:0] q_a_nxt, q_b_nxt;
  logic cfg_err_nxt, emul_nxt, collide_nxt;
  logic ce_ia, ce_oa, ce_ib, ce_ob;
  logic [13:0] ra, rb;
  logic [8:0] row_a, row_b;
  logic [39:0] dat_a, dat_b, view_a, view_b;
  logic wr_a, wr_b, rd_a, rd_b, shift_m, b_used;

  // physical bit p of a row -> bit of the addressed element, or -1
  function automatic int elem_idx(int p, logic [3:0] c, logic [13:0] a);
    int w;
    int d;
    int base;
    w = width_of(c);
    base = 0;
    if (LUT_BLOCK) begin
      d = p;
    end else if (is_par(c)) begin
      d = p;
    end else if (p % PAR_GROUP == PAR_GROUP - 1) begin
      d = -1;
    end else begin
      d = (p / PAR_GROUP) * 4 + p % PAR_GROUP;
    end
    if (!LUT_BLOCK) begin
      base = int'(a & ((14'h0001 << row_shift(c)) - 14'h0001)) * w;
    end
    if (d >= base && d < base + w) begin
      return d - base;
    end
    return -1;
  endfunction

  function automatic logic [8:0] row_of(logic [3:0] c, logic [13:0] a);
    logic [13:0] r;
    if (LUT_BLOCK) begin
      r = (width_of(c) <= LUT_EMUL_MAX_W) ? 14'(a % LUT_DEPTH_EMUL)
          : 14'(a % LUT_DEPTH_NATIVE);
    end else begin
      r = a >> row_shift(c);
    end
    return r[8:0];
  endfunction

  function automatic logic [39:0] rd_elem(logic [39:0] row,
      logic [3:0] c, logic [13:0] a);
    logic [39:0] o;
    int k;
    o = '0;
    for (int p = 0; p < ROW_W; p++) begin
      k = elem_idx(p, c, a);
      if (k >= 0) begin
        o[k] = row[p];
      end
    end
    return o;
  endfunction

  function automatic logic [39:0] wr_elem(logic [39:0] row,
      logic [39:0] wd, logic [3:0] c, logic [13:0] a);
    logic [39:0] o;
    int k;
    o = row;
    for (int p = 0; p < ROW_W; p++) begin
      k = elem_idx(p, c, a);
      if (k >= 0) begin
        o[p] = wd[k];
      end
    end
    return o;
  endfunction

  function automatic logic [39:0] wmask(logic [39:0] d, logic [3:0] c);
    return d & ((40'h00_0000_0001 << width_of(c)) - 40'h00_0000_0001);
  endfunction

  // enables per register group: {in A, out A, in B, out B}
  function automatic logic [3:0] ce_route(clk_mode_t m, logic a,
      logic b);
    case (m)
      CLK_SINGLE: return {a, a, a, a};
      CLK_IO: return {a, b, a, b};
      default: return {a, a, b, b};
    endcase
  endfunction

  function automatic logic lut_w(logic [3:0] c);
    return c == W8 || c == W9 || c == W10 || c == W16 || c == W18 ||
           c == W20;
  endfunction

  // configuration check
  always_comb begin
    cfg_err_nxt = 1'b0;
    b_used = mem_mode inside {MODE_SDP, MODE_TDP, MODE_FIFO};
    case (mem_mode)
      MODE_SP: cfg_err_nxt = !(clk_mode inside {CLK_SINGLE, CLK_IO});
      MODE_SDP: cfg_err_nxt = clk_mode == CLK_INDEP;
      MODE_TDP, MODE_ROM: cfg_err_nxt = clk_mode == CLK_RW;
      MODE_FIFO: cfg_err_nxt = !(clk_mode inside {CLK_SINGLE, CLK_RW});
      default: cfg_err_nxt = clk_mode != CLK_SINGLE;
    endcase
    if (LUT_BLOCK) begin
      if (mem_mode == MODE_TDP || !lut_w(wc_a)) begin
        cfg_err_nxt = 1'b1;
      end
      if (b_used && wc_b != wc_a) begin
        cfg_err_nxt = 1'b1;
      end
    end else begin
      if (wc_a inside {W9, W18} || wc_a > W40 ||
          (b_used && (wc_b inside {W9, W18} || wc_b > W40))) begin
        cfg_err_nxt = 1'b1;
      end
      if (b_used && is_par(wc_a) != is_par(wc_b)) begin
        cfg_err_nxt = 1'b1;
      end
      if (mem_mode == MODE_TDP && (wc_a >= W32 || wc_b >= W32)) begin
        cfg_err_nxt = 1'b1;
      end
    end
    if (mem_mode == MODE_SHIFT && width_of(wc_a) * TAP_LEN * TAP_CNT >
        (LUT_BLOCK ? CAP_LUT : CAP_LARGE)) begin
      cfg_err_nxt = 1'b1;
    end
    emul_nxt = LUT_BLOCK && width_of(wc_a) <= LUT_EMUL_MAX_W;
  end

  // input registers
  always_comb begin
    {ce_ia, ce_oa, ce_ib, ce_ob} = ce_route(clk_mode, ce_a, ce_b);
    // the lut block has no enable on write address and data
    a_addr_nxt = (ce_ia || LUT_BLOCK) ? addr_a : a_addr_r;
    a_wd_nxt = (ce_ia || LUT_BLOCK) ? data_a : a_wd_r;
    a_we_nxt = ce_ia ? we_a : a_we_r;
    a_re_nxt = ce_ia ? re_a : a_re_r;
    a_go_nxt = ce_ia;
    b_addr_nxt = ce_ib ? addr_b : b_addr_r;
    b_wd_nxt = ce_ib ? data_b : b_wd_r;
    b_we_nxt = ce_ib ? we_b : b_we_r;
    b_re_nxt = ce_ib ? re_b : b_re_r;
    b_go_nxt = ce_ib;
  end

  always_ff @(posedge clk) begin
    a_addr_r <= a_addr_nxt;
    a_wd_r <= a_wd_nxt;
    b_addr_r <= b_addr_nxt;
    b_wd_r <= b_wd_nxt;
    if (!rst_b) begin
      {a_we_r, a_re_r, a_go_r, b_we_r, b_re_r, b_go_r} <= '0;
    end else begin
      a_we_r <= a_we_nxt;
      a_re_r <= a_re_nxt;
      a_go_r <= a_go_nxt;
      b_we_r <= b_we_nxt;
      b_re_r <= b_re_nxt;
      b_go_r <= b_go_nxt;
    end
  end

  // clear pins come from outside: two flops before use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {clr_a_m, clr_a_s, clr_b_m, clr_b_s} <= '0;
    end else begin
      clr_a_m <= clr_a;
      clr_a_s <= clr_a_m;
      clr_b_m <= clr_b;
      clr_b_s <= clr_b_m;
    end
  end

  // memory access
  always_comb begin
    shift_m = mem_mode == MODE_SHIFT;
    // small rom may read its address pin unregistered
    ra = (LUT_BLOCK && !ROM_ADDR_REG && mem_mode == MODE_ROM) ?
         addr_a : a_addr_r;
    if (shift_m) begin
      ra = ptr_r;
    end
    rb = shift_m ? ptr_r : b_addr_r;
    row_a = row_of(wc_a, ra);
    row_b = row_of(shift_m ? wc_a : wc_b, rb);
    dat_a = mem[row_a];
    dat_b = mem[row_b];
    wr_a = a_go_r && a_we_r && !cfg_err && mem_mode != MODE_ROM;
    wr_b = b_go_r && b_we_r && !cfg_err && mem_mode == MODE_TDP;
    rd_a = a_go_r && (mem_mode inside {MODE_SP, MODE_TDP, MODE_ROM}) &&
           (a_re_r || !HAS_RE);
    rd_b = shift_m ? wr_a : b_go_r && b_used && (b_re_r || !HAS_RE);
    ptr_nxt = ptr_r;
    if (wr_a && shift_m) begin
      // oldest entry sits at the pointer, so one slot is both ends
      ptr_nxt = (int'(ptr_r) >= TAP_LEN * TAP_CNT - 1) ? '0 :
                ptr_r + 14'h0001;
    end
    view_a = rd_elem(dat_a, wc_a, ra);
    if (wr_a && rd_a) begin
      case (rdw_mode)
        RDW_NEW: view_a = wmask(a_wd_r, wc_a);
        RDW_OLD: view_a = rd_elem(dat_a, wc_a, ra);
        default: view_a = DONT_CARE_VAL;
      endcase
    end
    view_b = rd_elem(dat_b, shift_m ? wc_a : wc_b, rb);
    collide_nxt = 1'b0;
    if (wr_b && rd_b) begin
      case (rdw_mode)
        RDW_NEW: view_b = wmask(b_wd_r, wc_b);
        RDW_OLD: view_b = rd_elem(dat_b, wc_b, rb);
        default: view_b = DONT_CARE_VAL;
      endcase
    end else if (wr_a && rd_b && row_a == row_b &&
                 clk_mode == CLK_RW) begin
      view_b = DONT_CARE_VAL;
      collide_nxt = 1'b1;
    end
  end

  // port B lands last, so a same-row double write keeps port B
  always_ff @(posedge clk) begin
    if (wr_a) begin
      mem[row_a] <= wr_elem(dat_a, a_wd_r, wc_a, ra);
    end
    if (wr_b) begin
      mem[row_b] <= wr_elem(dat_b, b_wd_r, wc_b, rb);
    end
  end

  // output latches and registers, the only clearable state
  always_comb begin
    lat_a_nxt = lat_a_r;
    lat_b_nxt = lat_b_r;
    q_a_nxt = q_a;
    q_b_nxt = q_b;
    if (clr_a_s) begin
      lat_a_nxt = '0;
      q_a_nxt = '0;
    end else if (ce_oa) begin
      if (rd_a) begin
        lat_a_nxt = view_a;
      end
      q_a_nxt = OUT_REG ? lat_a_r : lat_a_nxt;
    end
    if (clr_b_s) begin
      lat_b_nxt = '0;
      q_b_nxt = '0;
    end else if (ce_ob) begin
      if (rd_b) begin
        lat_b_nxt = view_b;
      end
      q_b_nxt = OUT_REG ? lat_b_r : lat_b_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lat_a_r <= '0;
      lat_b_r <= '0;
      q_a <= '0;
      q_b <= '0;
      ptr_r <= '0;
      cfg_err <= 1'b0;
      emul <= 1'b0;
      collide <= 1'b0;
    end else begin
      lat_a_r <= lat_a_nxt;
      lat_b_r <= lat_b_nxt;
      q_a <= q_a_nxt;
      q_b <= q_b_nxt;
      ptr_r <= ptr_nxt;
      cfg_err <= cfg_err_nxt;
      emul <= emul_nxt;
      collide <= collide_nxt;
    end
  end

  hold_out_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce_oa && !clr_a_s |=> $stable(q_a))
    else $error("port A output moved with enable low");
  sp_write_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_mode == MODE_SP && wr_a && !rd_a && !clr_a_s |=> $stable(lat_a_r))
    else $error("single-port write without read changed output");
  clear_out_a: assert property (@(posedge clk) disable iff (!rst_b)
    clr_a_s |=> q_a == '0 && lat_a_r == '0)
    else $error("clear did not zero port A output");
  rom_no_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_mode == MODE_ROM |-> !wr_a && !wr_b)
    else $error("write in rom mode");
  lut_no_tdp_a: assert property (@(posedge clk) disable iff (!rst_b)
    LUT_BLOCK && mem_mode == MODE_TDP |=> cfg_err)
    else $error("lut block accepted true dual-port");
  family_mix_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_mode == MODE_SDP && is_par(wc_a) != is_par(wc_b) |=> cfg_err)
    else $error("mixed width families accepted");
  tdp_wide_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_mode == MODE_TDP && wc_a == W40 |=> cfg_err)
    else $error("512-word shape accepted in true dual-port");
  sp_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
    mem_mode == MODE_SP && clk_mode == CLK_RW |=> cfg_err)
    else $error("single-port accepted read/write clocking");
  lut_wr_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    LUT_BLOCK |=> a_addr_r == $past(addr_a) && a_wd_r == $past(data_a))
    else $error("lut write registers did not load");
  rw_collide_a: assert property (@(posedge clk) disable iff (!rst_b)
    collide |-> clk_mode == CLK_RW || $past(clk_mode) == CLK_RW)
    else $error("collision flagged outside read/write clocking");
endmodule

/* File: ram_fabric.sv */
`timescale 1ns/1ps
// fabric side of both ports: a request changes after a falling edge and
// holds over exactly one rising edge; on release the enables go low and the
// address and data lines show the inverse of their last value, which the lut block still loads on port A, where it has no enable on them
module ram_fabric (
  input wire logic clk,
  output logic [13:0] addr_a,
  output logic [39:0] data_a,
  output logic we_a,
  output logic re_a,
  output logic [13:0] addr_b,
  output logic [39:0] data_b,
  output logic we_b,
  output logic re_b
);
  initial begin
    addr_a = 14'h0000;
    data_a = 40'h00_0000_0000;
    we_a = 1'b0;
    re_a = 1'b0;
    addr_b = 14'h0000;
    data_b = 40'h00_0000_0000;
    we_b = 1'b0;
    re_b = 1'b0;
  end

  // same-row requests on both ports are issued only when the bench asks
  task automatic drive(input logic wa, input logic ra, input logic [13:0] aa,
    input logic [39:0] da, input logic wb, input logic rb,
    input logic [13:0] ab, input logic [39:0] db);
    @(negedge clk);
    we_a = wa;
    re_a = ra;
    addr_a = aa;
    data_a = da;
    we_b = wb;
    re_b = rb;
    addr_b = ab;
    data_b = db;
    @(posedge clk);
    @(negedge clk);
    we_a = 1'b0;
    re_a = 1'b0;
    we_b = 1'b0;
    re_b = 1'b0;
    addr_a = ~addr_a;
    data_a = ~data_a;
    addr_b = ~addr_b;
    data_b = ~data_b;
  endtask
endmodule

/* File: tb_ram_blk.sv */
`timescale 1ns/1ps
module tb_ram_blk;
  import ram_blk_pkg::*;
  typedef struct {int kind; logic [39:0] val;} note_t;
  logic clk, rst_b, ce_a, ce_b, clr_a, clr_b, hit;
  mem_mode_t mem_mode;
  clk_mode_t clk_mode;
  rdw_t rdw_mode;
  logic [3:0] wc_a, wc_b;
  logic [13:0] addr_a, addr_b;
  logic [39:0] data_a, data_b, q_a, q_b, v0, v1, v2, d, e, seen;
  logic we_a, re_a, we_b, re_b, cfg_err, emul, collide, cfg_err_l, emul_l;
  int n_errors, checks_done;
  logic [31:0] seed;
  note_t notes[$];
  note_t n;
  event look;
  mem_mode_t tm[9] = '{MODE_SDP, MODE_SDP, MODE_TDP, MODE_TDP, MODE_SP,
    MODE_FIFO, MODE_ROM, MODE_FIFO, MODE_SHIFT};
  clk_mode_t tc[9] = '{CLK_SINGLE, CLK_SINGLE, CLK_SINGLE, CLK_SINGLE,
    CLK_RW, CLK_IO, CLK_INDEP, CLK_RW, CLK_IO};
  logic [3:0] twa[9] = '{W5, W8, W32, W20, W8, W8, W8, W8, W8};
  logic [3:0] twb[9] = '{W8, W32, W32, W10, W8, W8, W8, W16, W8};
  logic terr[9] = '{1, 0, 1, 0, 1, 1, 0, 0, 1};
  logic lerr[9] = '{1, 1, 1, 1, 1, 1, 0, 1, 1};
  logic lemul[9] = '{1, 1, 0, 0, 1, 1, 1, 1, 1};

  ram_blk i_ram_blk (.clk(clk), .rst_b(rst_b), .mem_mode(mem_mode),
    .clk_mode(clk_mode), .rdw_mode(rdw_mode), .wc_a(wc_a), .wc_b(wc_b),
    .ce_a(ce_a), .ce_b(ce_b), .clr_a(clr_a), .clr_b(clr_b),
    .addr_a(addr_a), .data_a(data_a), .we_a(we_a), .re_a(re_a),
    .addr_b(addr_b), .data_b(data_b), .we_b(we_b), .re_b(re_b),
    .q_a(q_a), .q_b(q_b), .cfg_err(cfg_err), .emul(emul),
    .collide(collide));
  // lut copy only checks configuration; reads held off so its unwritten
  // rows never reach the outputs
  ram_blk #(.LUT_BLOCK(1'b1)) i_ram_blk_lut (.clk(clk), .rst_b(rst_b),
    .mem_mode(mem_mode), .clk_mode(clk_mode), .rdw_mode(rdw_mode),
    .wc_a(wc_a), .wc_b(wc_b), .ce_a(ce_a), .ce_b(ce_b), .clr_a(clr_a),
    .clr_b(clr_b), .addr_a(addr_a), .data_a(data_a), .we_a(1'b0),
    .re_a(1'b0), .addr_b(addr_b), .data_b(data_b), .we_b(1'b0),
    .re_b(1'b0), .q_a(), .q_b(), .cfg_err(cfg_err_l), .emul(emul_l),
    .collide());
  ram_fabric fab (.clk(clk), .addr_a(addr_a), .data_a(data_a),
    .we_a(we_a), .re_a(re_a), .addr_b(addr_b), .data_b(data_b),
    .we_b(we_b), .re_b(re_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // collide is a one-cycle pulse, so it is latched here rather than polled
  always @(negedge clk) begin
    if (collide === 1'b1) hit = 1'b1;
  end

  function automatic logic [39:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {seed[7:0], seed};
  endfunction

  // data bits of a 40-bit row with every fifth bit dropped
  function automatic logic [39:0] np32(logic [39:0] v);
    np32 = 40'h00_0000_0000;
    for (int i = 0; i < 8; i++) np32[4*i+:4] = v[5*i+:4];
  endfunction

  task automatic check(input logic [39:0] s, input logic [39:0] x);
    checks_done++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %0t: saw %h expected %h", $time, s, x);
    end
  endtask

  task automatic want(input int kind, input logic [39:0] x);
    notes.push_back('{kind, x});
    -> look;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one request, then wait capture edge plus two for the registered output
  task automatic op(input logic wa, input logic ra, input logic [13:0] aa,
    input logic [39:0] da, input logic rb, input logic [13:0] ab);
    fab.drive(wa, ra, aa, da, 1'b0, rb, ab, 40'h00_0000_0000);
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask

  task automatic cfg(input mem_mode_t m, input clk_mode_t c,
    input logic [3:0] a, input logic [3:0] b);
    @(negedge clk);
    mem_mode = m;
    clk_mode = c;
    wc_a = a;
    wc_b = b;
  endtask

  initial begin
    forever begin
      @(look);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.kind)
          0: seen = q_a;
          1: seen = q_b;
          2: seen = {39'h00_0000_0000, cfg_err};
          4: seen = {39'h00_0000_0000, cfg_err_l};
          5: seen = {39'h00_0000_0000, emul_l};
          6: seen = {39'h00_0000_0000, emul};
          default: seen = {39'h00_0000_0000, hit};
        endcase
        check(seen, n.val);
      end
    end
  end

  initial begin
    #400000;
    n_errors++;
    stop_test();
  end

  initial begin
    seed = 32'h0000_1f27;
    n_errors = 0;
    checks_done = 0;
    hit = 1'b0;
    rst_b = 1'b0;
    mem_mode = MODE_SP;
    clk_mode = CLK_SINGLE;
    rdw_mode = RDW_NEW;
    wc_a = W40;
    wc_b = W40;
    ce_a = 1'b1;
    ce_b = 1'b1;
    clr_a = 1'b0;
    clr_b = 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    v0 = rnd();
    v1 = rnd();
    v2 = rnd();
    op(1, 0, 14'h0005, v0, 0, 14'h0000);
    want(0, 40'h00_0000_0000);
    op(0, 1, 14'h0005, v0, 0, 14'h0000);
    want(0, v0);
    op(1, 0, 14'h0006, v1, 0, 14'h0000);
    want(0, v0);
    op(0, 1, 14'h0006, v1, 0, 14'h0000);
    want(0, v1);
    -> look;
    @(negedge clk);
    ce_a = 1'b0;
    op(1, 1, 14'h0005, v2, 0, 14'h0000);
    want(0, v1);
    @(negedge clk);
    ce_a = 1'b1;
    op(0, 1, 14'h0005, v2, 0, 14'h0000);
    want(0, v0);
    -> look;
    e = v1;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      rdw_mode = rdw_t'(3'h1 << k);
      d = rnd();
      op(1, 1, 14'h0006, d, 0, 14'h0000);
      want(0, k == 0 ? d : (k == 1 ? e : DONT_CARE_VAL));
      -> look;
      e = d;
    end
    // parity bits survive a narrow write because it never touches them
    op(1, 0, 14'h0003, v2, 0, 14'h0000);
    cfg(MODE_SP, CLK_SINGLE, W32, W32);
    op(0, 1, 14'h0003, v2, 0, 14'h0000);
    want(0, np32(v2));
    d = rnd() >> 8;
    op(1, 0, 14'h0003, d, 0, 14'h0000);
    cfg(MODE_SP, CLK_SINGLE, W40, W40);
    op(0, 1, 14'h0003, d, 0, 14'h0000);
    e = v2;
    for (int i = 0; i < 8; i++) e[5*i+:4] = d[4*i+:4];
    want(0, e);
    -> look;
    cfg(MODE_SDP, CLK_SINGLE, W8, W32);
    e = 40'h00_0000_0000;
    for (int j = 0; j < 4; j++) begin
      d = rnd() >> 32;
      op(1, 0, 14'(8 + j), d, 0, 14'h0000);
      e[8*j+:8] = d[7:0];
    end
    op(0, 0, 14'h0000, v0, 1, 14'h0002);
    want(1, e);
    -> look;
    for (int c = 0; c < 2; c++) begin
      cfg(MODE_SDP, c == 0 ? CLK_SINGLE : CLK_RW, W40, W40);
      d = rnd();
      op(1, 0, 14'h0007, d, 0, 14'h0000);
      hit = 1'b0;
      op(1, 0, 14'h0007, rnd(), 1, 14'h0007);
      repeat (2) @(posedge clk);
      #1;
      want(1, c == 0 ? d : DONT_CARE_VAL);
      want(3, {39'h00_0000_0000, c == 1});
      -> look;
    end
    for (int i = 0; i < 9; i++) begin
      cfg(tm[i], tc[i], twa[i], twb[i]);
      repeat (3) @(posedge clk);
      #1;
      want(2, {39'h00_0000_0000, terr[i]});
      want(4, {39'h00_0000_0000, lerr[i]});
      want(5, {39'h00_0000_0000, lemul[i]});
      want(6, 40'h00_0000_0000);
      -> look;
    end
    cfg(MODE_ROM, CLK_SINGLE, W40, W40);
    op(1, 1, 14'h0005, v1, 0, 14'h0000);
    want(0, v0);
    cfg(MODE_SP, CLK_SINGLE, W40, W40);
    op(0, 1, 14'h0005, v0, 0, 14'h0000);
    want(0, v0);
    -> look;
    @(negedge clk);
    clr_a = 1'b1;
    for (int i = 0; i < 8 && q_a !== 40'h00_0000_0000; i++) begin
      @(posedge clk);
      #1;
    end
    @(negedge clk);
    clr_a = 1'b0;
    want(0, 40'h00_0000_0000);
    -> look;
    op(0, 1, 14'h0005, v0, 0, 14'h0000);
    want(0, v0);
    -> look;
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
